// ===== hdl/isf_device.sv
// Sensor module end: sampling, framing, byte FIFO and serial ports
`timescale 1ns/10ps
`default_nettype none

module isf_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             clock,
   input  wire logic             rstn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [CW-1:0]    count_r;
   wire logic        push_w;
   wire logic        pop_w;

   assign in_ready  = count_r != CW'(DEPTH);
   assign out_valid = count_r != '0;
   assign out_data  = mem_r[rd_ptr_r];
   assign push_w    = in_valid & in_ready;
   assign pop_w     = out_valid & out_ready;

   always_ff @(posedge clock) begin
      if (push_w) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push_w) wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr_r + 1'b1);
         if (pop_w) rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr_r + 1'b1);
         count_r <= CW'(count_r + CW'(push_w) - CW'(pop_w));
      end
   end
endmodule

module isf_uart_tx
   import isf_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rstn,
   input  wire logic       byte_valid,
   output logic            byte_ready,
   input  wire logic [7:0] byte_data,
   output logic            line,
   output logic            busy
);
   logic [9:0] shift_r;
   logic [3:0] bits_r;
   logic [7:0] div_r;

   assign byte_ready = bits_r == 4'h0;
   assign busy       = !byte_ready;
   assign line       = shift_r[0];

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         shift_r <= 10'h3ff;
         bits_r  <= 4'h0;
         div_r   <= 8'h00;
      end else if (byte_valid && byte_ready) begin
         shift_r <= {1'b1, byte_data, 1'b0};
         bits_r  <= 4'ha;
         div_r   <= BIT_LAST;
      end else if (busy) begin
         if (div_r == 8'h00) begin
            shift_r <= {1'b1, shift_r[9:1]};
            bits_r  <= bits_r - 4'h1;
            div_r   <= BIT_LAST;
         end else begin
            div_r <= div_r - 8'h01;
         end
      end
   end
endmodule

module isf_uart_rx
   import isf_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rstn,
   input  wire logic       line,
   output logic            byte_valid,
   output logic [7:0]      byte_data
);
   logic [3:0] bits_r;
   logic [7:0] div_r;
   logic [7:0] shift_r;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         bits_r     <= 4'h0;
         div_r      <= 8'h00;
         shift_r    <= 8'h00;
         byte_valid <= 1'b0;
         byte_data  <= 8'h00;
      end else begin
         byte_valid <= 1'b0;
         if (bits_r == 4'h0) begin
            if (!line) begin
               bits_r <= 4'ha;
               div_r  <= HALF_BIT;
            end
         end else if (div_r != 8'h00) begin
            div_r <= div_r - 8'h01;
         end else begin
            div_r  <= BIT_LAST;
            bits_r <= bits_r - 4'h1;
            if (bits_r == 4'ha && line) begin
               bits_r <= 4'h0; // Glitch, not a start bit
            end else if (bits_r == 4'h1) begin
               byte_valid <= line;
               byte_data  <= shift_r;
            end else if (bits_r != 4'ha) begin
               shift_r <= {line, shift_r[7:1]};
            end
         end
      end
   end
endmodule

// Summary of operation
// - 460800 baud, 8N1 in both directions
// - Validity strobe falls when a sample is taken
// - Normal mode: strobe rises after message stop bit, or at compensation end for a sample not sent
// - Trigger falling edge sends newest completed sample
// - Trigger mode: strobe rises when compensation ends
// - Trigger ignored until trigger mode is enabled
// - Second pulse rising edge rounds time to second
// - Internal sampling at fixed 800 per second
// - Message opens with two 0xa5 sync bytes
// - Then type 0xa2 and payload length 0x1c
// - Acceleration field: code 0x81, length 0x0c
// - Angular rate field follows: code 0x82
// - X,Y,Z order, each float sent MSB first
// - Fletcher-16 tail, high block then low block
// - Output rate is sample rate over decimation
module isf_device
   import isf_pkg::*;
#(
   parameter int SAMPLE_PERIOD = SAMPLE_CYCLES
) (
   input  wire logic        clock,
   input  wire logic        rstn,
   isf_link_if.dev          link,
   input  wire isf_vec_t    sensor_in,
   input  wire logic        trig_mode_en,
   input  wire logic [15:0] decimation,
   output logic      [7:0]  cmd_byte,
   output logic             cmd_byte_valid,
   output logic      [31:0] time_sec,
   output logic      [9:0]  time_sub,
   output logic             msg_active
);
   localparam int PW = $clog2(SAMPLE_PERIOD + 1);

   logic [2:0]  trig_sync_r;
   logic [2:0]  pps_sync_r;
   logic [1:0]  rx_sync_r;
   logic [PW-1:0] period_r;
   logic [6:0]  comp_r;
   logic [15:0] decim_r;
   logic        sel_r;
   logic        have_sample_r;
   logic        wait_tx_r;
   logic        tov_r;
   isf_vec_t    taken_r;
   isf_vec_t    newest_r;
   isf_vec_t    tx_vec_r;
   logic        fr_busy_r;
   logic        drain_r;
   logic [5:0]  idx_r;
   logic [7:0]  sum1_r;
   logic [7:0]  sum2_r;
   logic [31:0] sec_r;
   logic [9:0]  sub_r;

   wire logic       trig_fall_w;
   wire logic       pps_rise_w;
   wire logic       tick_w;
   wire logic       comp_done_w;
   wire logic       decim_hit_w;
   wire logic       start_norm_w;
   wire logic       start_trig_w;
   wire logic       push_w;
   wire logic       fifo_ready_w;
   wire logic       fifo_valid_w;
   wire logic       tx_ready_w;
   wire logic       tx_busy_w;
   wire logic       tx_line_w;
   wire logic       msg_done_w;
   wire logic [7:0] fifo_data_w;
   wire logic [8:0] hdr_w;
   wire logic [5:0] off_w;
   wire logic [31:0] word_w;
   wire logic [7:0] s1_nxt;
   wire logic [7:0] s2_nxt;
   logic      [7:0] cur_byte;

   assign trig_fall_w  = trig_sync_r[2] & ~trig_sync_r[1] & trig_mode_en;
   assign pps_rise_w   = ~pps_sync_r[2] & pps_sync_r[1];
   assign tick_w       = period_r == '0;
   assign comp_done_w  = comp_r == 7'h01;
   assign decim_hit_w  = decim_r == 16'h0000;
   assign start_norm_w = comp_done_w & sel_r & !fr_busy_r & !drain_r;
   assign start_trig_w = trig_fall_w & have_sample_r & !fr_busy_r & !drain_r & !start_norm_w;
   assign push_w       = fr_busy_r & fifo_ready_w;
   assign msg_done_w   = drain_r & !fifo_valid_w & !tx_busy_w;
   assign hdr_w        = isf_hdr_byte(idx_r);
   assign off_w        = isf_data_off(idx_r);
   assign word_w       = tx_vec_r[off_w[4:2]];
   assign s1_nxt       = isf_mod_add(sum1_r, cur_byte);
   assign s2_nxt       = isf_mod_add(sum2_r, s1_nxt);

   always_comb begin
      cur_byte = word_w[8*(3 - off_w[1:0]) +: 8];
      if (hdr_w[8]) cur_byte = hdr_w[7:0];
      if (idx_r == IDX_CSUM_HI) cur_byte = sum1_r;
      if (idx_r == IDX_CSUM_LO) cur_byte = sum2_r;
   end

   // Trigger and second pulse take three stages: the first two synchronise, the third only remembers the old level; the receive line takes two
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         trig_sync_r <= 3'h7;
         pps_sync_r  <= 3'h0;
         rx_sync_r   <= 2'h3;
      end else begin
         trig_sync_r <= {trig_sync_r[1:0], link.ext_trigger_in};
         pps_sync_r  <= {pps_sync_r[1:0], link.gps_second_pulse_in};
         rx_sync_r   <= {rx_sync_r[0], link.rx_diff_pos & ~link.rx_diff_neg};
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         period_r      <= '0;
         comp_r        <= 7'h00;
         decim_r       <= 16'h0000;
         sel_r         <= 1'b0;
         have_sample_r <= 1'b0;
         taken_r       <= '0;
         newest_r      <= '0;
      end else begin
         period_r <= tick_w ? PW'(SAMPLE_PERIOD - 1) : PW'(period_r - 1'b1);
         if (comp_r != 7'h00) comp_r <= comp_r - 7'h01;
         if (comp_done_w) begin
            newest_r      <= taken_r;
            have_sample_r <= 1'b1;
         end
         if (tick_w) begin
            taken_r <= sensor_in;
            comp_r  <= COMP_LOAD;
            sel_r   <= decim_hit_w & !trig_mode_en & (decimation != 16'h0000);
            decim_r <= (decim_hit_w && decimation != 16'h0000) ? 16'(decimation - 16'h0001)
                       : (decim_hit_w ? 16'h0000 : 16'(decim_r - 16'h0001));
         end
      end
   end

   // Strobe: a new sample's fall beats any rise in the same cycle
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         tov_r     <= 1'b1;
         wait_tx_r <= 1'b0;
      end else if (tick_w) begin
         tov_r     <= 1'b0;
         wait_tx_r <= 1'b0;
      end else if (start_norm_w) begin
         wait_tx_r <= 1'b1;
      end else if (comp_done_w && !wait_tx_r) begin
         tov_r <= 1'b1;
      end else if (wait_tx_r && msg_done_w) begin
         tov_r     <= 1'b1;
         wait_tx_r <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         fr_busy_r <= 1'b0;
         drain_r   <= 1'b0;
         idx_r     <= 6'h00;
         sum1_r    <= 8'h00;
         sum2_r    <= 8'h00;
         tx_vec_r  <= '0;
      end else if (start_norm_w || start_trig_w) begin
         tx_vec_r  <= start_norm_w ? taken_r : newest_r;
         fr_busy_r <= 1'b1;
         idx_r     <= 6'h00;
         sum1_r    <= 8'h00;
         sum2_r    <= 8'h00;
      end else begin
         if (msg_done_w) drain_r <= 1'b0;
         if (push_w) begin
            idx_r <= idx_r + 6'h01;
            if (idx_r < IDX_CSUM_HI) begin
               sum1_r <= s1_nxt;
               sum2_r <= s2_nxt;
            end
            if (idx_r == IDX_CSUM_LO) begin
               fr_busy_r <= 1'b0;
               drain_r   <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sec_r <= 32'h0;
         sub_r <= 10'h0;
      end else if (pps_rise_w) begin
         sub_r <= 10'h0;
         if (sub_r >= SUB_HALF) sec_r <= sec_r + 32'h1;
      end else if (tick_w) begin
         sub_r <= (sub_r == SUB_LAST) ? 10'h0 : sub_r + 10'h1;
         if (sub_r == SUB_LAST) sec_r <= sec_r + 32'h1;
      end
   end

   // The FIFO soaks up framer bytes while the slow serialiser stalls it
   isf_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock     (clock),
      .rstn      (rstn),
      .in_valid  (fr_busy_r),
      .in_ready  (fifo_ready_w),
      .in_data   (cur_byte),
      .out_valid (fifo_valid_w),
      .out_ready (tx_ready_w),
      .out_data  (fifo_data_w)
   );

   isf_uart_tx u_tx (
      .clock      (clock),
      .rstn       (rstn),
      .byte_valid (fifo_valid_w),
      .byte_ready (tx_ready_w),
      .byte_data  (fifo_data_w),
      .line       (tx_line_w),
      .busy       (tx_busy_w)
   );

   isf_uart_rx u_rx (
      .clock      (clock),
      .rstn       (rstn),
      .line       (rx_sync_r[1]),
      .byte_valid (cmd_byte_valid),
      .byte_data  (cmd_byte)
   );

   assign link.tx_diff_pos            = tx_line_w;
   assign link.tx_diff_neg            = ~tx_line_w;
   assign link.sample_validity_strobe = tov_r;
   assign time_sec                    = sec_r;
   assign time_sub                    = sub_r;
   assign msg_active                  = fr_busy_r | drain_r;
endmodule
`default_nettype wire

// ===== hdl/isf_pkg.sv
// Constants and helpers shared by both ends of the inertial sample link
package isf_pkg;
   localparam int CLK_HZ         = 25_000_000;
   localparam int BAUD_BPS       = 460_800;
   localparam int BIT_CYCLES     = CLK_HZ / BAUD_BPS;
   localparam int SAMPLE_HZ      = 800;
   localparam int SAMPLE_CYCLES  = CLK_HZ / SAMPLE_HZ;
   localparam int COMP_CYCLES    = 64;
   localparam int TRIG_MIN_NS    = 1000;
   localparam int TRIG_CYCLES    = (TRIG_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int FIFO_WIDTH     = 8;
   localparam int FIFO_DEPTH     = 4;

   localparam logic [7:0] BIT_LAST      = 8'(BIT_CYCLES - 1);
   localparam logic [7:0] HALF_BIT      = 8'(BIT_CYCLES / 2 - 1);
   localparam logic [6:0] COMP_LOAD     = 7'(COMP_CYCLES);
   localparam logic [5:0] TRIG_LOAD     = 6'(TRIG_CYCLES);
   localparam logic [9:0] SUB_LAST      = 10'(SAMPLE_HZ - 1);
   localparam logic [9:0] SUB_HALF      = 10'(SAMPLE_HZ / 2);
   localparam logic [15:0] DECIM_RESET  = 16'h0008;

   localparam logic [5:0] IDX_ACC_DATA  = 6'h06;
   localparam logic [5:0] IDX_RATE_CODE = 6'h12;
   localparam logic [5:0] IDX_RATE_DATA = 6'h14;
   localparam logic [5:0] IDX_CSUM_HI   = 6'h20;
   localparam logic [5:0] IDX_CSUM_LO   = 6'h21;

   localparam logic [7:0] SYNC_BYTE     = 8'ha5;
   localparam logic [7:0] MSG_TYPE      = 8'ha2;
   localparam logic [7:0] PAYLOAD_LEN   = 8'h1c;
   localparam logic [7:0] CODE_ACCEL    = 8'h81;
   localparam logic [7:0] CODE_RATE     = 8'h82;
   localparam logic [7:0] FIELD_LEN     = 8'h0c;

   // Element 0..2 acceleration X,Y,Z; 3..5 angular rate X,Y,Z
   typedef logic [5:0][31:0] isf_vec_t;

   // Fixed framing byte at a message index: {is_fixed, value}
   function automatic logic [8:0] isf_hdr_byte(input logic [5:0] idx);
      logic [8:0] r;
      r = 9'h000;
      unique case (idx)
         6'h00, 6'h01: r = {1'b1, SYNC_BYTE};
         6'h02:        r = {1'b1, MSG_TYPE};
         6'h03:        r = {1'b1, PAYLOAD_LEN};
         6'h04:        r = {1'b1, CODE_ACCEL};
         6'h12:        r = {1'b1, CODE_RATE};
         6'h05, 6'h13: r = {1'b1, FIELD_LEN};
         default:      r = 9'h000;
      endcase
      return r;
   endfunction

   // Byte offset inside the six-word payload for a data index
   function automatic logic [5:0] isf_data_off(input logic [5:0] idx);
      return (idx < IDX_RATE_CODE) ? 6'(idx - IDX_ACC_DATA) : 6'(idx - IDX_RATE_DATA + 6'h0c);
   endfunction

   // Checksum blocks wrap modulo 256
   function automatic logic [7:0] isf_mod_add(input logic [7:0] a, input logic [7:0] b);
      return 8'(a + b);
   endfunction
endpackage

// ===== hdl/isf_link_if.sv
// Link between the sensor module and its host controller
`timescale 1ns/10ps
`default_nettype none
interface isf_link_if;
   logic tx_diff_pos;
   logic tx_diff_neg;
   logic rx_diff_pos;
   logic rx_diff_neg;
   logic sample_validity_strobe;
   logic ext_trigger_in;
   logic gps_second_pulse_in;

   modport dev (
      output tx_diff_pos, tx_diff_neg, sample_validity_strobe,
      input  rx_diff_pos, rx_diff_neg, ext_trigger_in, gps_second_pulse_in
   );
   modport host (
      input  tx_diff_pos, tx_diff_neg, sample_validity_strobe,
      output rx_diff_pos, rx_diff_neg, ext_trigger_in, gps_second_pulse_in
   );
endinterface
`default_nettype wire

// ===== hdl/isf_host.sv
// Host controller end: command sender, trigger and second pulse, message checker
`timescale 1ns/10ps
`default_nettype none
module isf_host
   import isf_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rstn,
   isf_link_if.host        link,
   input  wire logic       cmd_valid,
   output logic            cmd_ready,
   input  wire logic [7:0] cmd_data,
   input  wire logic       trig_req,
   input  wire logic       pps_level,
   output logic            msg_ok,
   output logic            msg_bad,
   output isf_vec_t        vec_out
);
   logic [5:0] trig_cnt_r;
   logic       trig_line_r;
   logic       pps_r;
   logic [5:0] pidx_r;
   logic [7:0] sum1_r;
   logic [7:0] sum2_r;
   logic       bad_r;
   isf_vec_t   acc_r;

   wire logic       rx_line_w;
   wire logic       rx_valid_w;
   wire logic [7:0] rx_byte_w;
   wire logic       tx_line_w;
   wire logic [8:0] hdr_w;
   wire logic [5:0] off_w;
   wire logic [7:0] s1_nxt;
   wire logic [7:0] s2_nxt;
   wire logic       mismatch_w;

   assign rx_line_w  = link.tx_diff_pos & ~link.tx_diff_neg;
   assign hdr_w      = isf_hdr_byte(pidx_r);
   assign off_w      = isf_data_off(pidx_r);
   assign s1_nxt     = isf_mod_add(sum1_r, rx_byte_w);
   assign s2_nxt     = isf_mod_add(sum2_r, s1_nxt);
   assign mismatch_w = hdr_w[8] && hdr_w[7:0] != rx_byte_w;

   // Trigger is held low for the minimum pulse width, then released
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         trig_cnt_r  <= 6'h00;
         trig_line_r <= 1'b1;
         pps_r       <= 1'b0;
      end else begin
         pps_r <= pps_level;
         if (trig_cnt_r != 6'h00) begin
            trig_cnt_r <= trig_cnt_r - 6'h01;
            if (trig_cnt_r == 6'h01) trig_line_r <= 1'b1;
         end else if (trig_req) begin
            trig_cnt_r  <= TRIG_LOAD;
            trig_line_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pidx_r  <= 6'h00;
         sum1_r  <= 8'h00;
         sum2_r  <= 8'h00;
         bad_r   <= 1'b0;
         acc_r   <= '0;
         vec_out <= '0;
         msg_ok  <= 1'b0;
         msg_bad <= 1'b0;
      end else begin
         msg_ok  <= 1'b0;
         msg_bad <= 1'b0;
         if (rx_valid_w) begin
            if (pidx_r == 6'h00) begin
               if (rx_byte_w == SYNC_BYTE) pidx_r <= 6'h01;
               sum1_r <= (rx_byte_w == SYNC_BYTE) ? SYNC_BYTE : 8'h00;
               sum2_r <= (rx_byte_w == SYNC_BYTE) ? SYNC_BYTE : 8'h00;
               bad_r  <= 1'b0;
            end else if (pidx_r == 6'h01 && rx_byte_w != SYNC_BYTE) begin
               pidx_r <= 6'h00;
               sum1_r <= 8'h00;
               sum2_r <= 8'h00;
            end else if (pidx_r < IDX_CSUM_HI) begin
               pidx_r <= pidx_r + 6'h01;
               sum1_r <= s1_nxt;
               sum2_r <= s2_nxt;
               if (mismatch_w) bad_r <= 1'b1;
               if (!hdr_w[8]) acc_r[off_w[4:2]][8*(3 - off_w[1:0]) +: 8] <= rx_byte_w;
            end else if (pidx_r == IDX_CSUM_HI) begin
               pidx_r <= IDX_CSUM_LO;
               if (rx_byte_w != sum1_r) bad_r <= 1'b1;
            end else begin
               pidx_r <= 6'h00;
               sum1_r <= 8'h00;
               sum2_r <= 8'h00;
               if (bad_r || rx_byte_w != sum2_r) begin
                  msg_bad <= 1'b1;
               end else begin
                  msg_ok  <= 1'b1;
                  vec_out <= acc_r;
               end
            end
         end
      end
   end

   isf_uart_rx u_rx (
      .clock      (clock),
      .rstn       (rstn),
      .line       (rx_line_w),
      .byte_valid (rx_valid_w),
      .byte_data  (rx_byte_w)
   );

   isf_uart_tx u_tx (
      .clock      (clock),
      .rstn       (rstn),
      .byte_valid (cmd_valid),
      .byte_ready (cmd_ready),
      .byte_data  (cmd_data),
      .line       (tx_line_w),
      .busy       ()
   );

   assign link.rx_diff_pos         = tx_line_w;
   assign link.rx_diff_neg         = ~tx_line_w;
   assign link.ext_trigger_in      = trig_line_r;
   assign link.gps_second_pulse_in = pps_r;
endmodule
`default_nettype wire

// ===== tb/isf_link_chk.sv
// Checker for the link wires between the sensor end and the host end
`timescale 1ns/10ps
`default_nettype none
module isf_link_chk #(
   parameter int SAMPLE_PERIOD = 31250
) (
   input  wire logic clock,
   input  wire logic rstn,
   input  wire logic tx_diff_pos,
   input  wire logic tx_diff_neg,
   input  wire logic rx_diff_pos,
   input  wire logic rx_diff_neg,
   input  wire logic sample_validity_strobe,
   input  wire logic ext_trigger_in,
   input  wire logic gps_second_pulse_in
);
   logic [9:0]  cyc_r;
   logic [9:0]  idle_r;
   logic [5:0]  idx_r;
   logic [7:0]  sh_r;
   logic [7:0]  s1_r;
   logic [7:0]  s2_r;
   logic [7:0]  a1_nxt;
   logic [7:0]  a2_nxt;
   logic [15:0] gap_r;
   logic        on_r;
   logic        sv_r;
   logic        seen_r;
   wire  logic  got  = on_r && cyc_r == 10'd512;
   // Sample mid-bit so a few cycles of skew still decode
   wire  logic  mid  = on_r && cyc_r % 10'd54 == 10'd26 && cyc_r > 10'd26 && cyc_r < 10'd512;
   wire  logic  gap  = idle_r == 10'd100;
   wire  logic  fall = sv_r && !sample_validity_strobe;

   function automatic logic [7:0] m256(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[7:0];
   endfunction
   assign a1_nxt = m256(s1_r, sh_r);
   assign a2_nxt = m256(s2_r, a1_nxt);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         {on_r, cyc_r, idle_r, idx_r, sh_r, s1_r, s2_r, gap_r, seen_r} <= '0;
         sv_r <= 1'b1;
      end else begin
         on_r   <= on_r ? !got : !tx_diff_pos;
         cyc_r  <= on_r ? cyc_r + 10'd1 : 10'd0;
         sh_r   <= mid ? {tx_diff_pos, sh_r[7:1]} : sh_r;
         idle_r <= (on_r || !tx_diff_pos) ? 10'd0 : idle_r + {9'h000, idle_r != 10'h3ff};
         // A long idle line marks a message boundary
         idx_r  <= gap ? 6'h00 : idx_r + {5'h00, got};
         s1_r   <= gap ? 8'h00 : (got && idx_r < 6'h20) ? a1_nxt : s1_r;
         s2_r   <= gap ? 8'h00 : (got && idx_r < 6'h20) ? a2_nxt : s2_r;
         sv_r   <= sample_validity_strobe;
         seen_r <= seen_r || fall;
         gap_r  <= fall ? 16'h0000 : gap_r + 16'h0001;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   property p_tx_diff; tx_diff_neg == !tx_diff_pos; endproperty
   a_tx_diff: assert property (p_tx_diff)
      else $error("tx pair not complementary");
   property p_rx_diff; rx_diff_neg == !rx_diff_pos; endproperty
   a_rx_diff: assert property (p_rx_diff)
      else $error("rx pair not complementary");
   property p_stop; got |-> tx_diff_pos; endproperty
   a_stop: assert property (p_stop)
      else $error("stop bit low");
   property p_sync; got && idx_r < 6'h02 |-> sh_r == 8'ha5; endproperty
   a_sync: assert property (p_sync)
      else $error("bad frame marker");
   property p_head; got && idx_r inside {6'h02, 6'h03} |-> sh_r == (idx_r[0] ? 8'h1c : 8'ha2); endproperty
   a_head: assert property (p_head)
      else $error("bad type or length");
   property p_acc; got && idx_r inside {6'h04, 6'h05} |-> sh_r == (idx_r[0] ? 8'h0c : 8'h81); endproperty
   a_acc: assert property (p_acc)
      else $error("bad accel field head");
   property p_rate; got && idx_r inside {6'h12, 6'h13} |-> sh_r == (idx_r[0] ? 8'h0c : 8'h82); endproperty
   a_rate: assert property (p_rate)
      else $error("bad rate field head");
   property p_csum; got && idx_r inside {6'h20, 6'h21} |-> sh_r == (idx_r[0] ? s2_r : s1_r); endproperty
   a_csum: assert property (p_csum)
      else $error("bad checksum");
   property p_nogap; got && idx_r < 6'h21 |-> ##[20:40] !tx_diff_pos; endproperty
   a_nogap: assert property (p_nogap)
      else $error("gap inside message");
   property p_tick; fall && seen_r |-> gap_r == 16'(SAMPLE_PERIOD - 1); endproperty
   a_tick: assert property (p_tick)
      else $error("sample period wrong");

   c_msg: cover property (got && idx_r == 6'h21);
   c_trig: cover property ($fell(ext_trigger_in));
   c_pps: cover property ($rose(gps_second_pulse_in));
endmodule
`default_nettype wire

// ===== tb/imu_sample_framer_sync_tb_top.sv
// Self-checking bench joining the sensor end and the host end
`timescale 1ns/10ps
`default_nettype none
module imu_sample_framer_sync_tb_top
   import isf_pkg::*;
;
   // Long enough that every decimation-1 message drains before the next tick
   localparam int PERIOD = 20000;
   typedef struct packed {isf_vec_t v; logic [9:0] sub;} isf_row_t;
   isf_row_t    rows [3];
   logic        clock = 1'b0;
   logic        rstn = 1'b0;
   isf_vec_t    sensor_in;
   logic        trig_mode_en = 1'b0;
   logic [15:0] decimation = 16'h0001;
   logic        cmd_valid = 1'b0;
   logic [7:0]  cmd_data = 8'h00;
   logic        trig_req = 1'b0;
   logic        pps_level = 1'b0;
   logic [7:0]  cmd_byte;
   logic        cmd_byte_valid;
   logic [31:0] time_sec;
   logic [9:0]  time_sub;
   logic        msg_active;
   logic        cmd_ready;
   logic        msg_ok;
   logic        msg_bad;
   isf_vec_t    vec_out;
   int          n_fail = 0;
   int          total_checks = 0;
   int          n_bad = 0;
   wire  logic [2:0] evt = {time_sub == 10'd1, cmd_byte_valid, msg_ok};

   isf_link_if isf_link_if_i ();
   isf_device #(.SAMPLE_PERIOD(PERIOD)) isf_device_i (.clock(clock), .rstn(rstn), .link(isf_link_if_i),
      .sensor_in(sensor_in), .trig_mode_en(trig_mode_en), .decimation(decimation), .cmd_byte(cmd_byte),
      .cmd_byte_valid(cmd_byte_valid), .time_sec(time_sec), .time_sub(time_sub), .msg_active(msg_active));
   isf_host isf_host_i (.clock(clock), .rstn(rstn), .link(isf_link_if_i), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_data(cmd_data), .trig_req(trig_req), .pps_level(pps_level),
      .msg_ok(msg_ok), .msg_bad(msg_bad), .vec_out(vec_out));
   isf_link_chk #(.SAMPLE_PERIOD(PERIOD)) isf_link_chk_i (.clock(clock), .rstn(rstn),
      .tx_diff_pos(isf_link_if_i.tx_diff_pos), .tx_diff_neg(isf_link_if_i.tx_diff_neg),
      .rx_diff_pos(isf_link_if_i.rx_diff_pos), .rx_diff_neg(isf_link_if_i.rx_diff_neg),
      .sample_validity_strobe(isf_link_if_i.sample_validity_strobe),
      .ext_trigger_in(isf_link_if_i.ext_trigger_in), .gps_second_pulse_in(isf_link_if_i.gps_second_pulse_in));

   always #20 clock = ~clock;
   always @(posedge clock) n_bad <= n_bad + int'(msg_bad === 1'b1);

   task automatic check(input logic [191:0] got, input logic [191:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // A timeout here counts as a mismatch
   task automatic wait_for(input int sel, input int lim);
      int k;
      k = 0;
      do begin
         @(negedge clock);
         k++;
      end while (evt[sel] !== 1'b1 && k < lim);
      if (k >= lim) check(1, 0);
   endtask

   task automatic pulse_trig();
      @(posedge clock);
      trig_req <= 1'b1;
      @(posedge clock);
      trig_req <= 1'b0;
   endtask

   task automatic end_of_test();
      $display("checks=%0d failures=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      #(40 * 95000);
      n_fail++;
      end_of_test();
   end

   initial begin
      rows[0] = '{{32'h3749539c, 32'h377ba882, 32'h37a7c5ac, 32'h3f800065, 32'h377ba882, 32'h37a7c5ac}, 10'd1};
      rows[1] = '{{6{32'hffffffff}}, 10'd2};
      rows[2] = '{{32'h06050403, 32'h02010000, 32'h80000000, 32'h0000ff00, 32'h00ff0000, 32'h12345678}, 10'd3};
      sensor_in = rows[0].v;
      repeat (8) @(posedge clock);
      rstn <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         @(posedge clock);
         cmd_valid <= 1'b1;
         cmd_data  <= 8'h01 << (7 * i);
         @(posedge clock);
         while (!cmd_ready) @(posedge clock);
         cmd_valid <= 1'b0;
         wait_for(1, 1000);
         check(cmd_byte, 8'h01 << (7 * i));
      end
      foreach (rows[i]) begin
         wait_for(0, PERIOD + 2000);
         check(vec_out, rows[i].v);
         check(time_sub, rows[i].sub);
         check(isf_link_if_i.sample_validity_strobe, 0);
         @(posedge clock);
         sensor_in <= rows[(i + 1) % 3].v;
         decimation <= 16'(i < 2);
      end
      pps_level <= 1'b1;
      repeat (6) @(posedge clock);
      check({time_sec, time_sub}, 0);
      pps_level <= 1'b0;
      pulse_trig();
      repeat (100) @(posedge clock);
      check(msg_active, 0);
      wait_for(2, PERIOD);
      repeat (100) @(posedge clock);
      trig_mode_en <= 1'b1;
      pulse_trig();
      repeat (100) @(posedge clock);
      check({msg_active, isf_link_if_i.sample_validity_strobe}, 2'b11);
      wait_for(0, PERIOD);
      check(vec_out, rows[0].v);
      rstn <= 1'b0;
      @(posedge clock);
      check({msg_active, time_sub, isf_link_if_i.sample_validity_strobe}, 1);
      check(n_bad, 0);
      end_of_test();
   end
endmodule
`default_nettype wire
